// >>> design/dpc_map.svh
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH
// timing
`define DPC_CLK_NS 4
`define DPC_NV_WRITE_MS 5
`define DPC_WIPER_DLY_NS 1000
// byte framing
`define DPC_LAST_BIT 4'h7
`define DPC_ACK_BIT 4'h8
// count loaded at a start: the start's own scl fall wraps it to zero
`define DPC_START_CNT 4'hF
// address byte fields
`define DPC_ID_HI 7
`define DPC_ID_LO 4
`define DPC_ADR_HI 3
`define DPC_ADR_LO 0
// instruction byte fields
`define DPC_OP_HI 7
`define DPC_OP_LO 4
`define DPC_SEL_HI 3
`define DPC_SEL_LO 2
`define DPC_ZERO_BIT 1
`define DPC_POT_BIT 0
// opcodes
`define DPC_OP_RD_WCR 4'h9
`define DPC_OP_WR_WCR 4'hA
`define DPC_OP_RD_DR 4'hB
`define DPC_OP_WR_DR 4'hC
`define DPC_OP_XFR_D2W 4'hD
`define DPC_OP_XFR_W2D 4'hE
`define DPC_OP_GXFR_D2W 4'h1
`define DPC_OP_GXFR_W2D 4'h8
`define DPC_OP_STEP 4'h2
// wiper range and reset values
`define DPC_POS_MAX 6'h3F
`define DPC_POS_RST 6'h00
`define DPC_SEL_ZERO 2'h0
`endif

// >>> design/dpc_pkg.sv
package dpc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_INSTR, ST_RX, ST_TX, ST_STEP, ST_HOLD
    } dpc_state_t;
    typedef logic [5:0] dpc_pos_t;
endpackage

// >>> design/dpc_decoder.sv
`timescale 1ns/1ns
`include "dpc_map.svh"
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module dpc_decoder
    import dpc_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE_ID = 4'hA, // arbitrary value
    parameter int NVW_CYCLES =
        `DPC_NV_WRITE_MS * 1000000 / `DPC_CLK_NS,
    parameter int WRL_CYCLES =
        (`DPC_WIPER_DLY_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS
)(
    // system
    input wire logic clock,
    input wire logic rst,
    // serial link, scl is also the link clock
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // straps and write guard
    input wire logic [3:0] strap_address_inputs,
    input wire logic wp_n,
    // tap switch selects and status
    output logic [63:0] tap_sel0,
    output logic [63:0] tap_sel1,
    output logic nv_busy
);

////////////////////////////////////////////////////////////////////////////
function automatic logic [63:0] one_hot(dpc_pos_t p);
    return 64'h1 << p;
endfunction

function automatic dpc_pos_t step_pos(dpc_pos_t p, logic up);
    dpc_pos_t r;
    r = p;
    if (up && p != `DPC_POS_MAX) begin
        r = dpc_pos_t'(p + 6'h01);
    end else if (!up && p != `DPC_POS_RST) begin
        r = dpc_pos_t'(p - 6'h01);
    end
    return r;
endfunction

function automatic logic instr_ok(logic [7:0] b);
    logic ok;
    logic wsel;
    ok = 1'b0;
    wsel = b[`DPC_SEL_HI:`DPC_SEL_LO] == `DPC_SEL_ZERO;
    case (b[`DPC_OP_HI:`DPC_OP_LO])
        `DPC_OP_RD_WCR, `DPC_OP_WR_WCR,
        `DPC_OP_STEP: ok = wsel && !b[`DPC_ZERO_BIT];
        `DPC_OP_RD_DR, `DPC_OP_WR_DR, `DPC_OP_XFR_D2W,
        `DPC_OP_XFR_W2D: ok = !b[`DPC_ZERO_BIT];
        `DPC_OP_GXFR_D2W,
        `DPC_OP_GXFR_W2D: ok = !b[`DPC_ZERO_BIT] && !b[`DPC_POT_BIT];
        default: ok = 1'b0;
    endcase
    return ok;
endfunction

////////////////////////////////////////////////////////////////////////////
// link domain: data sampled on the scl rising edge
logic link_bit_reg;

always_ff @(posedge scl) begin
    link_bit_reg <= sda_i;
end

////////////////////////////////////////////////////////////////////////////
// synchronisers
logic [1:0] scl_sync_reg;
logic [1:0] sda_sync_reg;
logic [1:0] bit_sync_reg;
logic [1:0] wp_sync_reg;
logic [3:0] strap_s1_reg;
logic [3:0] strap_s2_reg;
logic scl_d_reg;
logic sda_d_reg;

always_ff @(posedge clock) begin
    scl_sync_reg <= {scl_sync_reg[0], scl};
    sda_sync_reg <= {sda_sync_reg[0], sda_i};
    bit_sync_reg <= {bit_sync_reg[0], link_bit_reg};
    wp_sync_reg <= {wp_sync_reg[0], wp_n};
    strap_s1_reg <= strap_address_inputs;
    strap_s2_reg <= strap_s1_reg;
end

always_ff @(posedge clock) begin
    if (rst) begin
        scl_d_reg <= 1'b1;
        sda_d_reg <= 1'b1;
    end else begin
        scl_d_reg <= scl_sync_reg[1];
        sda_d_reg <= sda_sync_reg[1];
    end
end

// bits are taken on the falling scl edge, where the sampled bit is stable;
// a stop's final scl rise never falls, so it never counts as a step
logic start_ev;
logic stop_ev;
logic fall_ev;
logic sbit;

assign start_ev = scl_d_reg && scl_sync_reg[1] && sda_d_reg
    && !sda_sync_reg[1];
assign stop_ev = scl_d_reg && scl_sync_reg[1] && !sda_d_reg
    && sda_sync_reg[1];
assign fall_ev = scl_d_reg && !scl_sync_reg[1];
assign sbit = bit_sync_reg[1];

////////////////////////////////////////////////////////////////////////////
// byte framing and command state
dpc_state_t state_reg;
logic [3:0] bit_cnt_reg;
logic [6:0] shift_reg;
logic [3:0] op_reg;
logic [1:0] sel_reg;
logic pot_reg;
logic nv_busy_reg;
logic ack_now;
logic byte_end;
logic ack_end;
logic [7:0] byte_now;
logic is_read;

assign byte_now = {shift_reg, sbit};
assign byte_end = fall_ev && bit_cnt_reg == `DPC_LAST_BIT;
assign ack_end = fall_ev && bit_cnt_reg == `DPC_ACK_BIT;
assign is_read = op_reg == `DPC_OP_RD_WCR || op_reg == `DPC_OP_RD_DR;

always_comb begin
    unique case (state_reg)
        ST_ADDR: ack_now = byte_now[`DPC_ID_HI:`DPC_ID_LO] == DEV_TYPE_ID
            && byte_now[`DPC_ADR_HI:`DPC_ADR_LO] == strap_s2_reg
            && !nv_busy_reg;
        ST_INSTR: ack_now = instr_ok(byte_now);
        ST_RX: ack_now = 1'b1;
        default: ack_now = 1'b0;
    endcase
end

always_ff @(posedge clock) begin
    if (rst) begin
        state_reg <= ST_IDLE;
        bit_cnt_reg <= 4'h0;
        shift_reg <= 7'h00;
        op_reg <= 4'h0;
        sel_reg <= 2'h0;
        pot_reg <= 1'b0;
    end else if (start_ev) begin
        state_reg <= ST_ADDR;
        // the fall that ends a start carries no bit
        bit_cnt_reg <= `DPC_START_CNT;
    end else if (stop_ev) begin
        state_reg <= ST_IDLE;
    end else if (fall_ev && state_reg != ST_IDLE
                 && state_reg != ST_STEP) begin
        if (ack_end) begin
            bit_cnt_reg <= 4'h0;
            unique case (state_reg)
                ST_ADDR: state_reg <= ST_INSTR;
                ST_INSTR: begin
                    if (is_read) begin
                        state_reg <= ST_TX;
                    end else if (op_reg == `DPC_OP_WR_WCR
                                 || op_reg == `DPC_OP_WR_DR) begin
                        state_reg <= ST_RX;
                    end else if (op_reg == `DPC_OP_STEP) begin
                        state_reg <= ST_STEP;
                    end else begin
                        state_reg <= ST_HOLD;
                    end
                end
                default: state_reg <= ST_HOLD;
            endcase
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg <= byte_now[6:0];
            if (byte_end && state_reg == ST_INSTR) begin
                op_reg <= byte_now[`DPC_OP_HI:`DPC_OP_LO];
                sel_reg <= byte_now[`DPC_SEL_HI:`DPC_SEL_LO];
                pot_reg <= byte_now[`DPC_POT_BIT];
            end
            // ignore the rest of the frame after a refused byte
            if (byte_end && !ack_now
                && (state_reg == ST_ADDR || state_reg == ST_INSTR)) begin
                state_reg <= ST_IDLE;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// storage
dpc_pos_t wcr_reg [2];
dpc_pos_t dr_reg [2][4];

////////////////////////////////////////////////////////////////////////////
// open-drain data: output enable low pulls the line low
logic [7:0] tx_reg;
dpc_pos_t rd_val;

assign rd_val = op_reg == `DPC_OP_RD_WCR ? wcr_reg[pot_reg]
    : dr_reg[pot_reg][sel_reg];

always_ff @(posedge clock) begin
    if (rst || start_ev || stop_ev) begin
        sda_oe_n <= 1'b1;
        tx_reg <= 8'hFF;
    end else if (byte_end && ack_now) begin
        sda_oe_n <= 1'b0;
    end else if (ack_end && state_reg == ST_INSTR && is_read) begin
        sda_oe_n <= 1'b0;
        tx_reg <= {1'b0, rd_val, 1'b1};
    end else if (fall_ev && state_reg == ST_TX
                 && bit_cnt_reg < `DPC_LAST_BIT) begin
        sda_oe_n <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b1};
    end else if (fall_ev) begin
        sda_oe_n <= 1'b1;
    end
end

always_ff @(posedge clock) begin
    sda_o <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// wiper position registers
always_ff @(posedge clock) begin
    if (rst) begin
        for (int p = 0; p < 2; p++) begin
            wcr_reg[p] <= `DPC_POS_RST;
        end
    end else if (ack_end && state_reg == ST_INSTR) begin
        if (op_reg == `DPC_OP_XFR_D2W) begin
            wcr_reg[pot_reg] <= dr_reg[pot_reg][sel_reg];
        end else if (op_reg == `DPC_OP_GXFR_D2W) begin
            for (int p = 0; p < 2; p++) begin
                wcr_reg[p] <= dr_reg[p][sel_reg];
            end
        end
    end else if (ack_end && state_reg == ST_RX
                 && op_reg == `DPC_OP_WR_WCR) begin
        wcr_reg[pot_reg] <= shift_reg[5:0];
    end else if (fall_ev && state_reg == ST_STEP) begin
        wcr_reg[pot_reg] <= step_pos(wcr_reg[pot_reg], sbit);
    end
end

////////////////////////////////////////////////////////////////////////////
// nonvolatile write: armed by the command, started by its stop
logic nv_armed_reg;
logic nv_go;
logic [31:0] nv_cnt_reg;

assign nv_go = stop_ev && nv_armed_reg && wp_sync_reg[1];

always_ff @(posedge clock) begin
    if (rst || start_ev || stop_ev) begin
        nv_armed_reg <= 1'b0;
    end else if (ack_end && state_reg == ST_INSTR
                 && (op_reg == `DPC_OP_XFR_W2D
                     || op_reg == `DPC_OP_GXFR_W2D)) begin
        nv_armed_reg <= 1'b1;
    end else if (ack_end && state_reg == ST_RX
                 && op_reg == `DPC_OP_WR_DR) begin
        nv_armed_reg <= 1'b1;
    end
end

always_ff @(posedge clock) begin
    if (rst) begin
        nv_busy_reg <= 1'b0;
        nv_cnt_reg <= 32'h0;
    end else if (nv_go) begin
        nv_busy_reg <= 1'b1;
        nv_cnt_reg <= 32'h0;
    end else if (nv_busy_reg) begin
        nv_cnt_reg <= nv_cnt_reg + 32'h1;
        if (nv_cnt_reg == 32'(NVW_CYCLES - 1)) begin
            nv_busy_reg <= 1'b0;
        end
    end
end

// settings are committed at the stop that starts the write; the busy window hides them
always_ff @(posedge clock) begin
    if (rst) begin
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                dr_reg[p][s] <= `DPC_POS_RST;
            end
        end
    end else if (nv_go) begin
        if (op_reg == `DPC_OP_WR_DR) begin
            dr_reg[pot_reg][sel_reg] <= shift_reg[5:0];
        end else if (op_reg == `DPC_OP_XFR_W2D) begin
            dr_reg[pot_reg][sel_reg] <= wcr_reg[pot_reg];
        end else begin
            for (int p = 0; p < 2; p++) begin
                dr_reg[p][sel_reg] <= wcr_reg[p];
            end
        end
    end
end

assign nv_busy = nv_busy_reg;

////////////////////////////////////////////////////////////////////////////
// tap selects follow the wiper after the response delay;
// a whole new one-hot word is loaded, so two taps are never on
logic [31:0] dly_cnt_reg;
logic tap_diff;

assign tap_diff = tap_sel0 != one_hot(wcr_reg[0])
    || tap_sel1 != one_hot(wcr_reg[1]);

always_ff @(posedge clock) begin
    if (rst) begin
        dly_cnt_reg <= 32'h0;
        tap_sel0 <= one_hot(`DPC_POS_RST);
        tap_sel1 <= one_hot(`DPC_POS_RST);
    end else if (!tap_diff) begin
        dly_cnt_reg <= 32'h0;
    end else if (dly_cnt_reg == 32'(WRL_CYCLES - 1)) begin
        dly_cnt_reg <= 32'h0;
        tap_sel0 <= one_hot(wcr_reg[0]);
        tap_sel1 <= one_hot(wcr_reg[1]);
    end else begin
        dly_cnt_reg <= dly_cnt_reg + 32'h1;
    end
end

endmodule

// >>> verification/dpc_decoder_checker.sv
`timescale 1ns/1ns
module dpc_decoder_checker #(
    parameter int NVW_CYCLES = 200
)(
    // system
    input wire logic clock,
    input wire logic rst,
    // serial wire
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    // guard and outputs
    input wire logic wp_n,
    input wire logic [63:0] tap_sel0,
    input wire logic [63:0] tap_sel1,
    input wire logic nv_busy
);
    logic sda_q;
    int busy_cnt;
    int stop_age;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    // age of last stop, saturates so old stops never match
    always_ff @(posedge clock) begin
        sda_q <= sda_i;
        if (rst)
            stop_age <= 99;
        else if (scl && sda_i && !sda_q)
            stop_age <= 0;
        else if (stop_age < 99)
            stop_age <= stop_age + 1;
    end
    always_ff @(posedge clock) begin
        if (rst || !nv_busy)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_cnt + 1;
    end
    ////////////////////////////////////////////////////////////
    a_tap0_one_hot: assert property ($onehot(tap_sel0))
        else $error("tap select 0 not one-hot");
    a_tap1_one_hot: assert property ($onehot(tap_sel1))
        else $error("tap select 1 not one-hot");
    a_pin_drive_low: assert property (!sda_oe_n |-> !sda_o)
        else $error("data pin driven high");
    a_ack_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*3])
        else $error("pull-down too short");
    a_change_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
        else $error("data pin moved while clock high");
    a_busy_quiet: assert property (nv_busy |-> sda_oe_n)
        else $error("pin pulled while write busy");
    a_busy_len: assert property ($fell(nv_busy) |-> busy_cnt >= NVW_CYCLES)
        else $error("write cycle too short");
    a_busy_at_stop: assert property ($rose(nv_busy) |-> stop_age inside {[1:6]})
        else $error("write cycle without stop");
    a_guard_blocks: assert property ($rose(nv_busy) |-> wp_n)
        else $error("write cycle while guarded");
    c_busy: cover property ($rose(nv_busy));
    c_ack: cover property ($fell(sda_oe_n));
    c_tap1: cover property ($changed(tap_sel1));
endmodule
bind dpc_decoder dpc_decoder_checker #(.NVW_CYCLES(NVW_CYCLES)) chk_u (
    .clock(clock), .rst(rst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .wp_n(wp_n), .tap_sel0(tap_sel0),
    .tap_sel1(tap_sel1), .nv_busy(nv_busy)
);

// >>> verification/dpc_master.sv
`timescale 1ns/1ns
module dpc_master (
    // serial wire
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    // clock idles high and stands still between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    ////////////////////////////////////////////////////////////
    // 1 ns offset keeps every wire edge away from system clock edges
    task automatic start;
        #1 sda_m = 1'b1;
        #20 scl = 1'b1;
        #12 sda_m = 1'b0;
        #12 scl = 1'b0;
    endtask
    // nine pulses, msb first; a 1 releases the wire (pull-up)
    task automatic xb(input logic [8:0] d, output logic [8:0] r);
        for (int k = 8; k >= 0; k--) begin
            #20 sda_m = d[k];
            #4 scl = 1'b1;
            #12 r[k] = sda;
            #12 scl = 1'b0;
        end
    endtask
    task automatic stop;
        #20 sda_m = 1'b0;
        #4 scl = 1'b1;
        #12 sda_m = 1'b1;
        #12;
    endtask
endmodule

// >>> verification/tb_dpc_decoder.sv
`timescale 1ns/1ns
module tb_dpc_decoder;
    localparam logic [3:0] DEV_ID = 4'h6; // arbitrary value
    localparam logic [3:0] STRAP = 4'h9;
    localparam logic [7:0] ADR = {DEV_ID, STRAP};
    localparam int WRL = 4;
    logic clock, rst, scl, sda_m, wp_n, sda_o, sda_oe_n, nv_busy;
    logic [3:0] strap;
    logic [63:0] tap_sel0, tap_sel1;
    logic [8:0] r;
    int n_fail = 0;
    int cmp_count = 0;
    wire sda_w = sda_m & (sda_oe_n | sda_o);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    dpc_decoder #(.DEV_TYPE_ID(DEV_ID), .NVW_CYCLES(200), .WRL_CYCLES(WRL))
    dut_u (
        .clock(clock), .rst(rst), .scl(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .strap_address_inputs(strap), .wp_n(wp_n),
        .tap_sel0(tap_sel0), .tap_sel1(tap_sel1), .nv_busy(nv_busy)
    );
    dpc_master m (.scl(scl), .sda_m(sda_m), .sda(sda_w));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic adr(input logic [7:0] a, input logic e);
        @(posedge clock);
        m.start;
        m.xb({a, 1'b1}, r);
        chk(r[0], e);
    endtask
    task automatic ins(input logic [7:0] i, input logic e);
        adr(ADR, 1'b0);
        m.xb({i, 1'b1}, r);
        chk(r[0], e);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        ins(i, 1'b0);
        m.xb({d, 1'b1}, r);
        chk(r[0], 1'b0);
        m.stop;
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        ins(i, 1'b0);
        m.xb(9'h1FF, r);
        chk(r[8:1], e);
        m.stop;
    endtask
    task automatic nvw(input logic b);
        repeat (4) @(posedge clock);
        chk(nv_busy, b);
        if (b) begin
            adr(ADR, 1'b1);
            m.stop;
            for (int k = 0; k < 400 && nv_busy; k++) @(posedge clock);
            adr(ADR, 1'b0);
            m.stop;
        end
    endtask
    task automatic tp(input logic p, input logic [5:0] e);
        repeat (WRL + 6) @(posedge clock);
        chk(p ? tap_sel1 : tap_sel0, 64'h1 << e);
    endtask
    task automatic st(input logic [8:0] d, input logic [5:0] e);
        ins(8'h20, 1'b0);
        m.xb(d, r);
        m.stop;
        tp(1'b0, e);
    endtask
    task automatic complete_run;
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #300000;
        n_fail++;
        complete_run;
    end
    initial begin
        rst <= 1'b1;
        wp_n <= 1'b1;
        strap <= STRAP;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        chk(tap_sel0, 64'h1);
        adr({DEV_ID, ~STRAP}, 1'b1);
        m.stop;
        adr({~DEV_ID, STRAP}, 1'b1);
        m.stop;
        ins(8'h92, 1'b1);
        m.stop;
        ins(8'h24, 1'b1);
        m.stop;
        ins(8'h1D, 1'b1);
        m.stop;
        wr(8'hA1, 8'h2A);
        tp(1'b1, 6'h2A);
        rd(8'h91, 8'h2A);
        ins(8'hE9, 1'b0);
        m.stop;
        nvw(1'b1);
        wr(8'hA1, 8'h05);
        ins(8'hD9, 1'b0);
        m.stop;
        tp(1'b1, 6'h2A);
        rd(8'hB9, 8'h2A);
        wr(8'hC4, 8'h15);
        nvw(1'b1);
        rd(8'hB4, 8'h15);
        wr(8'hA0, 8'h3E);
        st(9'h1FF, 6'h3F);
        st(9'h000, 6'h36);
        ins(8'h8C, 1'b0);
        m.stop;
        nvw(1'b1);
        wr(8'hA0, 8'h00);
        wr(8'hA1, 8'h00);
        ins(8'h1C, 1'b0);
        m.stop;
        tp(1'b0, 6'h36);
        tp(1'b1, 6'h2A);
        wr(8'hA0, 8'h03);
        st(9'h000, 6'h00);
        wp_n <= 1'b0;
        wr(8'hC4, 8'h2B);
        nvw(1'b0);
        rd(8'hB4, 8'h15);
        wr(8'hA0, 8'h11);
        tp(1'b0, 6'h11);
        complete_run;
    end
endmodule
